// File: cfc_regs.vh
// constants for the CAN fault confinement block
`ifndef CFC_REGS_VH
`define CFC_REGS_VH
`define CFC_SYNC_BITS 11
`define CFC_BOFF_GROUPS 128
`define CFC_WARN_LIM 8'h60
`define CFC_PASS_LIM 8'h80
`define CFC_FLAG_BITS 6
`define CFC_DOM_ACT 14
`define CFC_DOM_PAS 8
`define CFC_DOM_STEP 8
`define CFC_INC_BIG 4'h8
`define CFC_INC_SMALL 4'h1
`define CFC_IFS_BITS 3
`define CFC_STUFF_RUN 6
`define CFC_DELIM_REST 7
`define CFC_REC_LSB 0
`define CFC_TEC_LSB 8
`define CFC_TALLY_RST 8'h00
`endif

// File: cfc_tally.v
// one 8-bit fault tally with add, subtract and clear
module cfc_tally #(
   parameter W = 8
) (
   input wire clk_i,
   input wire rst_i,
   input wire clr_i,
   input wire hold_i,
   input wire [3:0] inc_i,
   input wire dec_i,
   output reg [W-1:0] cnt_o,
   output reg ovf_o
);
   wire [W:0] sum;

   assign sum = {1'b0, cnt_o} + {{(W-3){1'b0}}, inc_i};

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_o <= {W{1'b0}};
         ovf_o <= 1'b0;
      end else if (clr_i) begin
         cnt_o <= {W{1'b0}};
         ovf_o <= 1'b0;
      end else if (inc_i != 4'h0 && !hold_i) begin
         // saturate; the carry marks a pass beyond full scale
         if (sum[W]) begin
            cnt_o <= {W{1'b1}};
            ovf_o <= 1'b1;
         end else begin
            cnt_o <= sum[W-1:0];
         end
      end else if (dec_i && cnt_o != {W{1'b0}}) begin
         cnt_o <= cnt_o - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// File: cfc_core.v
// CAN error detection and fault confinement core
`include "cfc_regs.vh"
module cfc_core #(
   parameter SYNC_BITS = `CFC_SYNC_BITS,
   parameter BOFF_GROUPS = `CFC_BOFF_GROUPS,
   parameter FLAG_BITS = `CFC_FLAG_BITS,
   parameter IFS_BITS = `CFC_IFS_BITS
) (
   input wire clk_i,
   input wire rst_i,
   input wire enable_i,
   input wire wakeup_i,
   input wire bit_tick_i,
   input wire rx_bit_i,
   input wire tx_bit_i,
   input wire transmitting_i,
   input wire arb_field_i,
   input wire stuffed_field_i,
   input wire stuff_bit_i,
   input wire ack_slot_i,
   input wire fixed_bit_i,
   input wire fixed_level_i,
   input wire last_eof_i,
   input wire crc_check_i,
   input wire crc_zero_i,
   input wire frame_ok_i,
   input wire frame_end_i,
   input wire overload_i,
   output reg drv_en_o,
   output reg flag_dom_o,
   output reg tx_ok_o,
   output reg err_bit_o,
   output reg err_stuff_o,
   output reg err_form_o,
   output reg err_crc_o,
   output reg err_ack_o,
   output reg [4:0] err_state_o,
   output wire [15:0] fault_tally_register_o
);
   localparam S_SYNC = 5'h01;
   localparam S_ACT = 5'h02;
   localparam S_WARN = 5'h04;
   localparam S_PAS = 5'h08;
   localparam S_OFF = 5'h10;

   localparam F_IDLE = 4'h1;
   localparam F_FLAG = 4'h2;
   localparam F_DOM = 4'h4;
   localparam F_DEL = 4'h8;

   localparam [3:0] SYNC_LAST = SYNC_BITS - 1;
   localparam [7:0] GRP_LAST = BOFF_GROUPS - 1;
   localparam [2:0] FLAG_LAST = FLAG_BITS - 1;
   localparam [2:0] DEL_LAST = `CFC_DELIM_REST - 1;
   localparam [3:0] RUN_LAST = `CFC_STUFF_RUN - 1;
   localparam [1:0] IFS_FULL = IFS_BITS;
   localparam [3:0] DOM_ACT = `CFC_DOM_ACT;
   localparam [3:0] DOM_PAS = `CFC_DOM_PAS;
   localparam [3:0] DOM_STEP = `CFC_DOM_STEP;

   // tally state to fault state while taking part in traffic
   function [4:0] st_eval;
      input [7:0] receive_fault_tally;
      input [7:0] transmit_fault_tally;
      input ovf;
      begin
         if (ovf)
            st_eval = S_OFF;
         else if (receive_fault_tally[7] || transmit_fault_tally >= `CFC_PASS_LIM)
            st_eval = S_PAS;
         else if (receive_fault_tally >= `CFC_WARN_LIM || transmit_fault_tally >= `CFC_WARN_LIM)
            st_eval = S_WARN;
         else
            st_eval = S_ACT;
      end
   endfunction

   reg [4:0] st_q;
   reg [3:0] fl_q;
   reg [3:0] scnt_q;
   reg [7:0] gcnt_q;
   reg [3:0] run_q;
   reg last_q;
   reg [2:0] fcnt_q;
   reg [3:0] dcnt_q;
   reg grp_q;
   reg first_q;
   reg act_q;
   reg role_q;
   reg pend_q;
   reg saw_q;
   reg ovl_q;
   reg [1:0] ifs_q;

   reg [3:0] rec_inc;
   reg [3:0] tec_inc;

   wire [7:0] receive_fault_tally;
   wire [7:0] transmit_fault_tally;
   wire tec_ovf;

   wire part;
   wire passive;
   wire idle_chk;
   wire arb_ok;
   wire e_bit;
   wire e_stuff;
   wire e_form;
   wire e_crc;
   wire e_ack;
   wire e_any;
   wire no_tec;
   wire defer_ack;
   wire ovl_start;
   wire flag_err;
   wire flag_end;
   wire dom_hit;
   wire first_dom;
   wire del_err;
   wire del_done;
   wire boff_done;
   wire [3:0] dom_lim;

   assign part = (st_q == S_ACT) || (st_q == S_WARN) || (st_q == S_PAS);
   assign passive = (st_q == S_PAS);
   assign idle_chk = bit_tick_i && part && (fl_q == F_IDLE);

   // dominant over recessive is allowed in arbitration and ack slot
   assign arb_ok = tx_bit_i && !rx_bit_i && (arb_field_i || ack_slot_i);
   assign e_bit = idle_chk && transmitting_i &&
      (rx_bit_i != tx_bit_i) && !arb_ok;
   assign e_stuff = idle_chk && stuffed_field_i &&
      (run_q == RUN_LAST) && (rx_bit_i == last_q);
   assign e_form = idle_chk && fixed_bit_i &&
      (rx_bit_i != fixed_level_i) &&
      !(last_eof_i && !transmitting_i && !rx_bit_i);
   assign e_crc = idle_chk && crc_check_i && !crc_zero_i &&
      !transmitting_i;
   assign e_ack = idle_chk && transmitting_i && ack_slot_i &&
      rx_bit_i;
   assign e_any = e_bit || e_stuff || e_form || e_crc || e_ack;

   // recessive stuff bit in arbitration seen dominant
   assign no_tec = e_stuff && arb_field_i && stuff_bit_i &&
      tx_bit_i && !rx_bit_i;
   assign defer_ack = e_ack && passive;
   assign ovl_start = idle_chk && overload_i && !e_any;

   assign flag_err = bit_tick_i && (fl_q == F_FLAG) && act_q &&
      rx_bit_i;
   assign flag_end = bit_tick_i && (fl_q == F_FLAG) &&
      (fcnt_q == FLAG_LAST);
   assign dom_lim = grp_q ? DOM_STEP : (act_q ? DOM_ACT : DOM_PAS);
   assign dom_hit = bit_tick_i && (fl_q == F_DOM) && !rx_bit_i &&
      (dcnt_q + 4'h1 == dom_lim);
   assign first_dom = bit_tick_i && (fl_q == F_DOM) && first_q &&
      !rx_bit_i && !role_q && !ovl_q;
   assign del_err = bit_tick_i && (fl_q == F_DEL) && !rx_bit_i &&
      part;
   assign del_done = bit_tick_i && (fl_q == F_DEL) && rx_bit_i &&
      (fcnt_q == DEL_LAST);

   assign boff_done = bit_tick_i && (st_q == S_OFF) && rx_bit_i &&
      (scnt_q == SYNC_LAST) && (gcnt_q == GRP_LAST) &&
      enable_i && !wakeup_i;

   // tally increments of this cycle
   always @* begin
      rec_inc = 4'h0;
      tec_inc = 4'h0;
      if (e_any || del_err) begin
         if (transmitting_i) begin
            if (!no_tec && !defer_ack)
               tec_inc = `CFC_INC_BIG;
         end else begin
            rec_inc = `CFC_INC_SMALL;
         end
      end
      if (flag_err || dom_hit) begin
         if (role_q)
            tec_inc = `CFC_INC_BIG;
         else
            rec_inc = `CFC_INC_BIG;
      end
      if (first_dom)
         rec_inc = `CFC_INC_BIG;
      // deferred ack error counts only if dominant seen in flag
      if (flag_end && pend_q && (saw_q || !rx_bit_i))
         tec_inc = `CFC_INC_BIG;
   end

   cfc_tally #(
      .W(8)
   ) u_rec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(boff_done),
      .hold_i(receive_fault_tally[7]),
      .inc_i(rec_inc),
      .dec_i(frame_ok_i && !transmitting_i),
      .cnt_o(receive_fault_tally),
      .ovf_o()
   );

   cfc_tally #(
      .W(8)
   ) u_tec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(boff_done),
      .hold_i(1'b0),
      .inc_i(tec_inc),
      .dec_i(frame_ok_i && transmitting_i),
      .cnt_o(transmit_fault_tally),
      .ovf_o(tec_ovf)
   );

   assign fault_tally_register_o = {transmit_fault_tally, receive_fault_tally};

   // fault state machine
   always @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= S_SYNC;
         scnt_q <= 4'h0;
         gcnt_q <= 8'h00;
      end else if (!enable_i || wakeup_i) begin
         st_q <= S_SYNC;
         scnt_q <= 4'h0;
         gcnt_q <= 8'h00;
      end else begin
         case (st_q)
            S_SYNC: begin
               if (bit_tick_i) begin
                  if (!rx_bit_i)
                     scnt_q <= 4'h0;
                  else if (scnt_q == SYNC_LAST) begin
                     st_q <= S_ACT;
                     scnt_q <= 4'h0;
                  end else
                     scnt_q <= scnt_q + 4'h1;
               end
            end
            S_OFF: begin
               // count groups of eleven recessive bits
               if (bit_tick_i) begin
                  if (!rx_bit_i)
                     scnt_q <= 4'h0;
                  else if (scnt_q == SYNC_LAST) begin
                     scnt_q <= 4'h0;
                     if (gcnt_q == GRP_LAST) begin
                        st_q <= S_ACT;
                        gcnt_q <= 8'h00;
                     end else
                        gcnt_q <= gcnt_q + 8'h01;
                  end else
                     scnt_q <= scnt_q + 4'h1;
               end
            end
            S_ACT, S_WARN, S_PAS: begin
               st_q <= st_eval(receive_fault_tally, transmit_fault_tally, tec_ovf);
               scnt_q <= 4'h0;
               gcnt_q <= 8'h00;
            end
            default: begin
               st_q <= S_SYNC;
               scnt_q <= 4'h0;
               gcnt_q <= 8'h00;
            end
         endcase
      end
   end

   // error and overload flag sequencer
   always @(posedge clk_i) begin
      if (rst_i || !part) begin
         fl_q <= F_IDLE;
         fcnt_q <= 3'h0;
         dcnt_q <= 4'h0;
         grp_q <= 1'b0;
         first_q <= 1'b0;
         act_q <= 1'b0;
         role_q <= 1'b0;
         pend_q <= 1'b0;
         saw_q <= 1'b0;
         ovl_q <= 1'b0;
         flag_dom_o <= 1'b0;
      end else begin
         case (fl_q)
            F_IDLE: begin
               if (e_any || ovl_start) begin
                  fl_q <= F_FLAG;
                  fcnt_q <= 3'h0;
                  // flag kind from state before this error's count
                  act_q <= ovl_start || !passive;
                  flag_dom_o <= ovl_start || !passive;
                  role_q <= transmitting_i;
                  pend_q <= defer_ack;
                  saw_q <= 1'b0;
                  ovl_q <= ovl_start;
               end
            end
            F_FLAG: begin
               if (bit_tick_i) begin
                  if (!rx_bit_i)
                     saw_q <= 1'b1;
                  if (fcnt_q == FLAG_LAST) begin
                     fl_q <= F_DOM;
                     flag_dom_o <= 1'b0;
                     first_q <= 1'b1;
                     dcnt_q <= 4'h0;
                     grp_q <= 1'b0;
                     pend_q <= 1'b0;
                  end else
                     fcnt_q <= fcnt_q + 3'h1;
               end
            end
            F_DOM: begin
               if (bit_tick_i) begin
                  first_q <= 1'b0;
                  if (rx_bit_i) begin
                     fl_q <= F_DEL;
                     fcnt_q <= 3'h0;
                  end else if (dom_hit) begin
                     dcnt_q <= 4'h0;
                     grp_q <= 1'b1;
                  end else
                     dcnt_q <= dcnt_q + 4'h1;
               end
            end
            F_DEL: begin
               if (del_err) begin
                  // dominant delimiter bit: new flag
                  fl_q <= F_FLAG;
                  fcnt_q <= 3'h0;
                  act_q <= !passive;
                  flag_dom_o <= !passive;
                  role_q <= transmitting_i;
                  pend_q <= 1'b0;
                  saw_q <= 1'b0;
                  ovl_q <= 1'b0;
               end else if (del_done)
                  fl_q <= F_IDLE;
               else if (bit_tick_i)
                  fcnt_q <= fcnt_q + 3'h1;
            end
            default: begin
               fl_q <= F_IDLE;
               flag_dom_o <= 1'b0;
            end
         endcase
      end
   end

   // stuff run tracking and interframe space
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 4'h0;
         last_q <= 1'b1;
         ifs_q <= 2'h0;
      end else begin
         if (bit_tick_i) begin
            last_q <= rx_bit_i;
            if (!stuffed_field_i)
               run_q <= 4'h0;
            else if (rx_bit_i == last_q && run_q != RUN_LAST)
               run_q <= run_q + 4'h1;
            else if (rx_bit_i != last_q)
               run_q <= 4'h1;
         end
         if (st_q == S_SYNC)
            ifs_q <= IFS_FULL;
         else if (frame_end_i || del_done || fl_q != F_IDLE)
            ifs_q <= 2'h0;
         else if (bit_tick_i && !rx_bit_i)
            ifs_q <= 2'h0;
         else if (bit_tick_i && ifs_q != IFS_FULL)
            ifs_q <= ifs_q + 2'h1;
      end
   end

   // registered outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         drv_en_o <= 1'b0;
         tx_ok_o <= 1'b0;
         err_bit_o <= 1'b0;
         err_stuff_o <= 1'b0;
         err_form_o <= 1'b0;
         err_crc_o <= 1'b0;
         err_ack_o <= 1'b0;
         err_state_o <= S_SYNC;
      end else begin
         drv_en_o <= part;
         tx_ok_o <= part && (fl_q == F_IDLE) &&
            (ifs_q == IFS_FULL);
         err_bit_o <= e_bit || flag_err;
         err_stuff_o <= e_stuff;
         err_form_o <= e_form || del_err;
         err_crc_o <= e_crc;
         err_ack_o <= e_ack;
         err_state_o <= st_q;
      end
   end
endmodule

// File: cfc_bus_model.sv
// other nodes on the shared bus, wired with our own driver
module cfc_bus_model (
   input logic drv_en_i,
   input logic tx_bit_i,
   input logic flag_dom_i,
   input logic node_bit_i,
   output logic bus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic own;
   // a released driver leaves the pull-up level on the wire
   assign own = drv_en_i ? (tx_bit_i & ~flag_dom_i) : 1'b1;
   assign bus_o = own & node_bit_i;
endmodule

// File: cfc_core_properties.sv
// assertions on the outputs of the fault confinement core
module cfc_props (
   input logic clk_i,
   input logic rst_i,
   input logic flag_dom_o,
   input logic tx_ok_o,
   input logic err_bit_o,
   input logic err_stuff_o,
   input logic err_form_o,
   input logic err_crc_o,
   input logic err_ack_o,
   input logic [4:0] err_state_o,
   input logic [15:0] fault_tally_register_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [7:0] rc;
   logic [7:0] tc;
   logic [4:0] er;
   logic hi;
   logic mid;
   assign rc = fault_tally_register_o[7:0];
   assign tc = fault_tally_register_o[15:8];
   assign er = {err_bit_o, err_stuff_o, err_form_o, err_crc_o, err_ack_o};
   assign hi = rc > 8'h7F || tc > 8'h7F;
   assign mid = rc > 8'h5F || tc > 8'h5F;
   sequence flag_run;
      flag_dom_o [*8];
   endsequence
   pulse_one_a:
      assert property (|er |=> er == 5'h00) else $error("long error pulse");
   onehot_st_a:
      assert property ($onehot(err_state_o)) else $error("state not one-hot");
   flag_len_a:
      assert property ($rose(flag_dom_o) |-> flag_run)
      else $error("dominant flag too short");
   flag_gate_a:
      assert property (flag_dom_o && $past(flag_dom_o) |-> !tx_ok_o)
      else $error("frame start allowed during flag");
   rec_step_a:
      assert property (rc != $past(rc) |-> rc == $past(rc) + 8'h01
         || rc == $past(rc) + 8'h08 || rc == $past(rc) - 8'h01 || rc == 8'h00)
      else $error("bad receive tally step");
   tec_step_a:
      assert property (tc != $past(tc) |-> tc == $past(tc) + 8'h08
         || tc == $past(tc) - 8'h01 || tc == 8'h00 || tc == 8'hFF)
      else $error("bad transmit tally step");
   pass_cause_a:
      assert property (err_state_o == 5'h08 |->
         $past(hi) || $past(hi, 2) || $past(hi, 3))
      else $error("passive without high tally");
   warn_cause_a:
      assert property (err_state_o == 5'h04 |->
         $past(mid) || $past(mid, 2) || $past(mid, 3))
      else $error("warning without tally of 96");
   boff_quiet_a:
      assert property (err_state_o == 5'h10 && $past(err_state_o) == 5'h10
         |-> er == 5'h00)
      else $error("error reported while bus off");
   boff_clear_a:
      assert property ($fell(err_state_o[4]) |-> fault_tally_register_o == 0)
      else $error("tallies not cleared leaving bus off");
   sync_quiet_a:
      assert property (err_state_o == 5'h01 |-> !flag_dom_o)
      else $error("flag sent while synchronizing");
endmodule
bind cfc_core cfc_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .flag_dom_o(flag_dom_o), .tx_ok_o(tx_ok_o), .err_bit_o(err_bit_o),
   .err_stuff_o(err_stuff_o), .err_form_o(err_form_o),
   .err_crc_o(err_crc_o), .err_ack_o(err_ack_o),
   .err_state_o(err_state_o), .fault_tally_register_o(fault_tally_register_o));

// File: cfc_core_bench.sv
// self-checking bench for the fault confinement core
module cfc_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic enable_i = 1'b0;
   logic wakeup_i = 1'b0;
   logic tick = 1'b0;
   logic tx_bit = 1'b1;
   logic node = 1'b1;
   logic frame_ok = 1'b0;
   logic eof = 1'b0;
   logic [6:0] f = 7'h00;
   logic [4:0] seen = 5'h00;
   logic [15:0] lfsr = 16'h3C90;
   logic rx_bit, drv_en, flag_dom, tx_ok;
   logic [4:0] errs, st;
   logic [15:0] tally;
   int n_fail = 0;
   int n_checks = 0;
   int erec = 0;
   int etec = 0;
   int eboff = 0;
   int esync = 1;
   int i;
   cfc_bus_model bus (.drv_en_i(drv_en), .tx_bit_i(tx_bit),
      .flag_dom_i(flag_dom), .node_bit_i(node), .bus_o(rx_bit));
   cfc_core uut (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
      .wakeup_i(wakeup_i), .bit_tick_i(tick), .rx_bit_i(rx_bit),
      .tx_bit_i(tx_bit), .transmitting_i(f[6]), .arb_field_i(f[5]),
      .stuffed_field_i(f[4]), .stuff_bit_i(f[3]), .ack_slot_i(f[2]),
      .fixed_bit_i(f[1]), .fixed_level_i(1'b1), .last_eof_i(eof),
      .crc_check_i(f[0]), .crc_zero_i(1'b0), .frame_ok_i(frame_ok),
      .frame_end_i(1'b0), .overload_i(1'b0), .drv_en_o(drv_en),
      .flag_dom_o(flag_dom), .tx_ok_o(tx_ok), .err_bit_o(errs[4]),
      .err_stuff_o(errs[3]), .err_form_o(errs[2]), .err_crc_o(errs[1]),
      .err_ack_o(errs[0]), .err_state_o(st), .fault_tally_register_o(tally));
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) seen <= seen | errs;
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [4:0] est();
      if (esync != 0) return 5'h01;
      if (eboff != 0) return 5'h10;
      if (etec > 127 || erec > 127) return 5'h08;
      if (etec > 95 || erec > 95) return 5'h04;
      return 5'h02;
   endfunction
   task automatic chk(input string nm, input logic [15:0] sv, ev);
      n_checks++;
      if (sv !== ev) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, ev, sv);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one bit time: a quiet cycle, then tick high for a cycle
   task automatic tk(input logic nb, input logic tb, input logic [6:0] fl);
      @(negedge clk_i);
      node = nb;
      tx_bit = tb;
      f = fl;
      tick = 1'b1;
      seen = 5'h00;
      @(negedge clk_i);
      tick = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) tk(1'b1, 1'b1, 7'h00);
   endtask
   task automatic look(input string nm);
      repeat (2) @(negedge clk_i);
      chk({nm, " tally"}, tally, {etec[7:0], erec[7:0]});
      chk({nm, " state"}, 16'(st), 16'(est()));
   endtask
   task automatic okf(input logic tr);
      @(negedge clk_i);
      f = {tr, 6'h00};
      frame_ok = 1'b1;
      @(negedge clk_i);
      frame_ok = 1'b0;
      if (tr) etec = etec > 0 ? etec - 1 : 0;
      else erec = erec > 0 ? erec - 1 : 0;
      look("valid frame");
   endtask
   // one detected error, its flag and the recovery to idle
   task automatic hit(input logic nb, input logic tb, input logic [6:0] fl,
      input int k, input int dr, input int dt, input bit fd);
      logic [4:0] pre;
      pre = est();
      tk(nb, tb, fl);
      erec += dr;
      etec += dt;
      if (etec > 255) begin
         eboff = 1;
         etec = 255;
      end
      @(negedge clk_i);
      chk("error kind", 16'(seen), 16'h0001 << k);
      if (eboff == 0) begin
         chk("flag level", 16'(flag_dom), 16'(pre < 5'h08));
         chk("frame gate", 16'(tx_ok), 16'h0000);
         if (fd) begin
            idle(6);
            tk(1'b0, 1'b1, 7'h00);
            erec += 8;
         end
         idle(20);
         if (est() < 5'h08) chk("frame gate", 16'(tx_ok), 16'h0001);
      end
      look("after error");
   endtask
   initial begin
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      look("reset");
      chk("drive", 16'(drv_en), 16'h0000);
      enable_i = 1'b1;
      idle(10);
      look("sync wait");
      idle(1);
      esync = 0;
      look("sync done");
      chk("drive", 16'(drv_en), 16'h0001);
      chk("frame gate", 16'(tx_ok), 16'h0001);
      $display("test sync finished");
      hit(1'b0, 1'b1, 7'h02, 2, 1, 0, 0);
      hit(1'b0, 1'b1, 7'h02, 2, 1, 0, 1);
      repeat (5) tk(1'b0, 1'b1, 7'h10);
      hit(1'b0, 1'b1, 7'h10, 3, 1, 0, 0);
      hit(1'b1, 1'b1, 7'h01, 1, 1, 0, 0);
      hit(1'b1, 1'b1, 7'h44, 0, 0, 8, 0);
      tk(1'b0, 1'b1, 7'h78);
      @(negedge clk_i);
      chk("arbitration", 16'(seen), 16'h0000);
      look("arbitration");
      // sixth equal bit is a recessive stuff bit read back dominant
      repeat (4) tk(1'b0, 1'b0, 7'h70);
      hit(1'b0, 1'b1, 7'h78, 3, 0, 0, 0);
      eof = 1'b1;
      tk(1'b0, 1'b1, 7'h02);
      eof = 1'b0;
      @(negedge clk_i);
      chk("last eof bit", 16'(seen), 16'h0000);
      look("last eof bit");
      $display("test error kinds finished");
      for (i = 0; i < 12; i++) begin
         lfsr = nxt(lfsr);
         okf(lfsr[0]);
      end
      $display("test valid frames finished");
      while (etec < 128) hit(1'b0, 1'b1, 7'h40, 4, 0, 8, 0);
      hit(1'b1, 1'b1, 7'h44, 0, 0, 0, 0);
      while (etec > 127) okf(1'b1);
      while (eboff == 0) hit(1'b0, 1'b1, 7'h40, 4, 0, 8, 0);
      chk("drive", 16'(drv_en), 16'h0000);
      $display("test confinement finished");
      idle(5);
      tk(1'b0, 1'b1, 7'h00);
      idle(1407);
      look("bus off wait");
      idle(1);
      erec = 0;
      etec = 0;
      eboff = 0;
      look("bus off exit");
      $display("test recovery finished");
      @(negedge clk_i);
      wakeup_i = 1'b1;
      @(negedge clk_i);
      wakeup_i = 1'b0;
      esync = 1;
      look("wake");
      idle(11);
      esync = 0;
      look("wake sync");
      enable_i = 1'b0;
      esync = 1;
      look("disable");
      enable_i = 1'b1;
      idle(11);
      esync = 0;
      look("enable sync");
      $display("test wake finished");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      test_done();
   end
endmodule
